// [logic/dpc_defs.svh]
// constants for the playback command handler: command codes, field positions, reset values, timing
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH
`define DPC_CMD_PLAY 16'h000D
`define DPC_CMD_RESET 16'h8000
`define DPC_CMD_SCAN 16'h000A
`define DPC_CMD_BLANK 16'h030F
`define DPC_CMD_BORDER 16'h0407
`define DPC_BLANK_BIT 0
`define DPC_LEFT_MSB 9
`define DPC_TOP_MSB 14
`define DPC_RESET_BLANK 1'b1
`define DPC_RESET_COLOUR 8'h00
`define DPC_RESET_LEFT 10'h000
`define DPC_RESET_TOP 15'h0000
`define DPC_RESET_CYCLES 4'h8
`endif

// [logic/dpc_pkg.sv]
// types shared by the playback command handler
package dpc_pkg;
  typedef enum logic [2:0] {
    DPC_IDLE, DPC_SETUP, DPC_PLAY, DPC_SCAN, DPC_PAUSE, DPC_RESETTING
  } dpc_state_e;
endpackage

// [logic/dpc_command_handler.sv]
// playback command handler: play, reset, scan, blank and border commands
//==================================================================
// Contract
// - play code 000D enters PLAY, passing PLAY-SETUP when needed
// - PLAY decodes and displays at bitstream rate, time stamps align display
// - reset code 8000 discards bitstream buffer, command queue, picture buffers
// - reset reinitialises display, blanks window with border colour, restores defaults
// - only reset among high-priority commands changes command state
// - reset is not finished when the new-command flag clears
// - scan code 000A enters SCAN, decodes one intra picture
// - in SCAN, sync does not gate picture decode timing
// - scan completion moves to PAUSE, raises scan-done if enabled; here a command taken in the same cycle wins and the completion is lost
// - before first intra picture, headers decoded, P and B discarded
// - after scan picture, bitstream consumption stops until PAUSE left
// - scan picture shown at once, kept until next play-type command
// - blank code 030F, arg bit0 selects blank, bits 15:1 zero
// - blanked window shows border colour, unblanked shows pictures
// - blanking keeps border colour and does not disturb decoding; here a blank taken in the scan_picture_done cycle blocks the move to PAUSE
// - blank change appears after first VSYNC following the command
// - border code 0407, second argument bits 14:0 top offset
// - border first argument bits 9:0 left offset
// - colour: third arg red/Cr bits 7:0, fourth green/Y and blue/Cb
// - PAUSE holds last picture and keeps processing commands
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defs.svh"
module dpc_command_handler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // command area
  input wire logic cmd_new,
  input wire logic [15:0] cmd_code,
  input wire logic [15:0] left_offset_arg,
  input wire logic [15:0] top_offset_arg,
  input wire logic [15:0] red_colour_arg,
  input wire logic [15:0] green_blue_colour_arg,
  output logic cmd_taken,
  output logic reset_busy,
  // decode engine status
  input wire logic setup_needed,
  input wire logic intra_seen,
  input wire logic scan_picture_done,
  input wire logic scan_irq_enable,
  input wire logic vsync,
  // playback state and decode control
  output dpc_pkg::dpc_state_e play_state,
  output logic decode_run,
  output logic sync_enable,
  output logic discard_pred,
  output logic post_scan_picture,
  output logic flush_buffers,
  output logic display_reinit,
  output logic scan_done_interrupt,
  // display settings
  output logic window_blank,
  output logic [9:0] left_offset,
  output logic [14:0] top_offset,
  output logic [7:0] red_colour,
  output logic [7:0] green_colour,
  output logic [7:0] blue_colour
);
  import dpc_pkg::*;

  //==================================================================
  // command state
  dpc_state_e state_r, state_nxt;
  logic [3:0] rst_cnt_r, rst_cnt_nxt;
  logic taken_r, taken_nxt;
  logic flush_r, flush_nxt;
  logic reinit_r, reinit_nxt;
  logic irq_r, irq_nxt;
  logic post_r, post_nxt;
  logic scan_hold_r, scan_hold_nxt;
  logic busy_r, busy_nxt;

  // handshake with the host:
  // - a command is taken on an edge where cmd_new is high and cmd_taken is low
  // - cmd_taken answers one cycle later and stands for exactly one cycle
  // - the host must drop cmd_new once it sees cmd_taken, or the same
  //   command is taken again two cycles later
  // - nothing is taken while a reset command is still running
  // - unknown codes are taken and have no effect beyond masking a same-cycle scan_picture_done or holding setup one more cycle, so the host never stalls
  // the reset command runs for DPC_RESET_CYCLES plus one cycles after it is
  // taken; the host must watch reset_busy, not cmd_taken, to see it finish
  // hazard: play while already playing is accepted and simply re-enters play;
  // the host is the one obliged to avoid it
  // scan with setup_needed high passes through setup for one cycle and
  // scan_hold_r remembers that scan, not play, is the target

  // a held strobe is taken again two cycles later; the strobe must drop before the next
  function automatic logic is_cmd(input logic [15:0] code, input logic [15:0] want);
    return code == want;
  endfunction

  // state transitions; reset is the only high-priority command touching state
  always_comb begin
    state_nxt = state_r;
    rst_cnt_nxt = rst_cnt_r;
    taken_nxt = 1'b0;
    flush_nxt = 1'b0;
    reinit_nxt = 1'b0;
    irq_nxt = 1'b0;
    post_nxt = post_r;
    scan_hold_nxt = scan_hold_r;
    if (state_r == DPC_RESETTING) begin
      // reset still runs after the new-command flag clears
      if (rst_cnt_r == 4'h0) begin
        state_nxt = DPC_IDLE;
      end else begin
        rst_cnt_nxt = rst_cnt_r - 4'h1;
      end
    end else if (cmd_new && !taken_r) begin
      taken_nxt = 1'b1;
      if (is_cmd(cmd_code, `DPC_CMD_RESET)) begin
        state_nxt = DPC_RESETTING;
        rst_cnt_nxt = `DPC_RESET_CYCLES;
        flush_nxt = 1'b1;
        reinit_nxt = 1'b1;
        post_nxt = 1'b0;
        scan_hold_nxt = 1'b0;
      end else if (is_cmd(cmd_code, `DPC_CMD_PLAY)) begin
        state_nxt = setup_needed ? DPC_SETUP : DPC_PLAY;
        post_nxt = 1'b0;
        scan_hold_nxt = 1'b0;
      end else if (is_cmd(cmd_code, `DPC_CMD_SCAN)) begin
        state_nxt = setup_needed ? DPC_SETUP : DPC_SCAN;
        scan_hold_nxt = 1'b1;
        post_nxt = 1'b0;
      end
    end else begin
      unique case (state_r)
        DPC_SETUP: state_nxt = scan_hold_r ? DPC_SCAN : DPC_PLAY;
        DPC_SCAN: begin
          if (scan_picture_done) begin
            state_nxt = DPC_PAUSE;
            irq_nxt = scan_irq_enable;
            post_nxt = 1'b1;
          end
        end
        DPC_IDLE, DPC_PLAY, DPC_PAUSE: state_nxt = state_r;
        default: state_nxt = DPC_IDLE;
      endcase
    end
    // registered busy flag keeps reset_busy a plain flip-flop output
    busy_nxt = (state_nxt == DPC_RESETTING);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= DPC_IDLE;
      rst_cnt_r <= 4'h0;
      taken_r <= 1'b0;
      flush_r <= 1'b0;
      reinit_r <= 1'b0;
      irq_r <= 1'b0;
      post_r <= 1'b0;
      scan_hold_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      taken_r <= taken_nxt;
      flush_r <= flush_nxt;
      reinit_r <= reinit_nxt;
      irq_r <= irq_nxt;
      post_r <= post_nxt;
      scan_hold_r <= scan_hold_nxt;
      busy_r <= busy_nxt;
    end
  end

  //==================================================================
  // decode control outputs, registered from next state
  // these levels are computed from the next state so they change on the
  // same edge as play_state and never lag it by a cycle
  // decode_run: the bitstream is consumed only in play and scan
  // sync_enable: time-stamp alignment applies in play only; scan decodes
  //   its picture as fast as the engine allows
  // discard_pred: predicted pictures are dropped in scan until the engine
  //   reports the first intra picture
  logic run_r, run_nxt, sync_r, sync_nxt, disc_r, disc_nxt;

  // scan ignores sync; pause and idle stop consuming the bitstream
  always_comb begin
    run_nxt = (state_nxt == DPC_PLAY) || (state_nxt == DPC_SCAN);
    sync_nxt = (state_nxt == DPC_PLAY);
    disc_nxt = (state_nxt == DPC_SCAN) && !intra_seen;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      run_r <= 1'b0;
      sync_r <= 1'b0;
      disc_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      sync_r <= sync_nxt;
      disc_r <= disc_nxt;
    end
  end

  //==================================================================
  // display settings; blank request held until the next vsync
  // a blank request is parked in pend_r with its value in pend_val_r and
  // reaches window_blank on the first vsync sampled after the taking edge
  // a vsync on the taking edge itself is too early and does not count
  // a later blank request before that vsync overrides the parked value
  // border geometry and colour take effect at once; only the defined
  // bit fields of each argument word are kept, the rest is ignored
  // limitation: zero offsets are stored as given, no centring is done here
  // reset blanks at once and cancels any parked request, since the window
  // must show the border colour while the display restarts
  logic blank_r, blank_nxt, pend_r, pend_nxt, pend_val_r, pend_val_nxt;
  logic [9:0] left_r, left_nxt;
  logic [14:0] top_r, top_nxt;
  logic [7:0] red_r, red_nxt, grn_r, grn_nxt, blu_r, blu_nxt;
  logic accept;

  always_comb begin
    accept = cmd_new && !taken_r && (state_r != DPC_RESETTING);
    blank_nxt = blank_r;
    pend_nxt = pend_r;
    pend_val_nxt = pend_val_r;
    left_nxt = left_r;
    top_nxt = top_r;
    red_nxt = red_r;
    grn_nxt = grn_r;
    blu_nxt = blu_r;
    // vsync applies a pending blank change; a same-cycle command waits for the next one
    if (vsync && pend_r) begin
      blank_nxt = pend_val_r;
      pend_nxt = 1'b0;
    end
    if (accept && is_cmd(cmd_code, `DPC_CMD_BLANK)) begin
      pend_nxt = 1'b1;
      pend_val_nxt = left_offset_arg[`DPC_BLANK_BIT];
    end
    if (accept && is_cmd(cmd_code, `DPC_CMD_BORDER)) begin
      left_nxt = left_offset_arg[`DPC_LEFT_MSB:0];
      top_nxt = top_offset_arg[`DPC_TOP_MSB:0];
      red_nxt = red_colour_arg[7:0];
      grn_nxt = green_blue_colour_arg[15:8];
      blu_nxt = green_blue_colour_arg[7:0];
    end
    // reset blanks at once with the colour kept, and restores default geometry
    if (accept && is_cmd(cmd_code, `DPC_CMD_RESET)) begin
      blank_nxt = `DPC_RESET_BLANK;
      pend_nxt = 1'b0;
      left_nxt = `DPC_RESET_LEFT;
      top_nxt = `DPC_RESET_TOP;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      blank_r <= `DPC_RESET_BLANK;
      pend_r <= 1'b0;
      pend_val_r <= 1'b0;
      left_r <= `DPC_RESET_LEFT;
      top_r <= `DPC_RESET_TOP;
      red_r <= `DPC_RESET_COLOUR;
      grn_r <= `DPC_RESET_COLOUR;
      blu_r <= `DPC_RESET_COLOUR;
    end else begin
      blank_r <= blank_nxt;
      pend_r <= pend_nxt;
      pend_val_r <= pend_val_nxt;
      left_r <= left_nxt;
      top_r <= top_nxt;
      red_r <= red_nxt;
      grn_r <= grn_nxt;
      blu_r <= blu_nxt;
    end
  end

  // outputs straight from flip-flops
  // every output below is a plain register copy, so no decode logic
  // sits between a flip-flop and a pin
  // reset_busy is registered from the next state for the same reason
  assign play_state = state_r;
  assign cmd_taken = taken_r;
  assign reset_busy = busy_r;
  assign decode_run = run_r;
  assign sync_enable = sync_r;
  assign discard_pred = disc_r;
  assign post_scan_picture = post_r;
  assign flush_buffers = flush_r;
  assign display_reinit = reinit_r;
  assign scan_done_interrupt = irq_r;
  assign window_blank = blank_r;
  assign left_offset = left_r;
  assign top_offset = top_r;
  assign red_colour = red_r;
  assign green_colour = grn_r;
  assign blue_colour = blu_r;
endmodule
`default_nettype wire

// [testbench/dpc_checker.sv]
// concurrent checks on the playback command handler ports
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defs.svh"
module dpc_checker import dpc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // command handshake
  input wire logic [15:0] cmd_code,
  input wire logic cmd_taken,
  input wire logic reset_busy,
  // engine status
  input wire logic vsync,
  input wire logic scan_picture_done,
  input wire logic scan_irq_enable,
  // results
  input wire dpc_state_e play_state,
  input wire logic flush_buffers,
  input wire logic display_reinit,
  input wire logic scan_done_interrupt,
  input wire logic window_blank
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  //==================================================
  // command effects, judged in the cycle cmd_taken shows
  chk_play_enter: assert property (cmd_taken && cmd_code == `DPC_CMD_PLAY |-> play_state inside {DPC_SETUP, DPC_PLAY})
    else $error("play did not start");
  chk_scan_enter: assert property (cmd_taken && cmd_code == `DPC_CMD_SCAN |-> play_state inside {DPC_SETUP, DPC_PLAY, DPC_SCAN})
    else $error("scan did not start");
  chk_reset_effects: assert property (cmd_taken && cmd_code == `DPC_CMD_RESET |-> flush_buffers && display_reinit && window_blank && reset_busy)
    else $error("reset effects missing");
  chk_reset_length: assert property ($rose(reset_busy) |-> reset_busy [*8] ##1 reset_busy ##1 !reset_busy)
    else $error("reset length wrong");
  chk_busy_refuse: assert property (reset_busy |=> !cmd_taken)
    else $error("command taken during reset");
  chk_flush_only: assert property (flush_buffers |-> reset_busy && cmd_taken)
    else $error("flush without reset");
  chk_scan_pause: assert property (play_state == DPC_SCAN && scan_picture_done |=>
    play_state == DPC_PAUSE && scan_done_interrupt == $past(scan_irq_enable))
    else $error("scan end wrong");
  // a sync reset also forces blanking, so it is excused here
  chk_blank_vsync: assert property ($changed(window_blank) |-> $past(vsync) || reset_busy || !$past(nrst))
    else $error("blank changed off vsync");
  cover property (cmd_taken && cmd_code == `DPC_CMD_RESET);
  cover property (scan_done_interrupt);
  cover property ($fell(window_blank));
endmodule
`default_nettype wire

// [testbench/dpc_host_model.sv]
// host model: loads one command and holds it until taken
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defs.svh"
module dpc_host_model (
  // clock and handshake
  input wire logic clk_sys,
  input wire logic cmd_taken,
  input wire logic reset_busy,
  // command area
  output logic cmd_new,
  output logic [15:0] cmd_code,
  output logic [3:0][15:0] arg
);
  logic tmo;
  // idle command area at time zero
  initial begin
    cmd_new = 1'b0;
    cmd_code = 16'h0000;
    arg = '0;
    tmo = 1'b0;
  end
  // released words go inverted so stale data never looks valid; model never holds a memory semaphore
  task automatic issue(input logic [15:0] c, input logic [63:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_new <= 1'b1;
    cmd_code <= c;
    arg <= a;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!cmd_taken && n < 40);
    cmd_new <= 1'b0;
    cmd_code <= ~c;
    arg <= ~a;
    // reset still runs after the flag clears
    while (c == `DPC_CMD_RESET && reset_busy && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    tmo = (n >= 40);
  endtask
endmodule
`default_nettype wire

// [testbench/dpc_command_handler_bench.sv]
// self-checking bench for the playback command handler
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defs.svh"
module dpc_command_handler_bench;
  import dpc_pkg::*;
  //==================================================
  // signals
  logic clk_sys, nrst, vsync, scan_picture_done, intra_seen, setup_needed, scan_irq_enable;
  logic cmd_new, cmd_taken, reset_busy, decode_run, sync_enable, discard_pred, post_scan_picture;
  logic flush_buffers, display_reinit, scan_done_interrupt, window_blank, b, wb;
  logic [15:0] cmd_code;
  logic [3:0][15:0] arg;
  logic [63:0] a;
  logic [31:0] lfsr;
  logic [9:0] left_offset;
  logic [14:0] top_offset;
  logic [7:0] red_colour, green_colour, blue_colour;
  dpc_state_e play_state;
  wire logic [15:0] left_offset_arg = arg[0];
  wire logic [15:0] top_offset_arg = arg[1];
  wire logic [15:0] red_colour_arg = arg[2];
  wire logic [15:0] green_blue_colour_arg = arg[3];
  int err_count, n_tests;
  logic irq_seen = 1'b0;
  logic rst_seen = 1'b0;
  // sticky records of one-cycle pulses, so the sequence can compare them later
  always @(posedge clk_sys) begin
    if (scan_done_interrupt) irq_seen <= 1'b1;
    if (flush_buffers && display_reinit) rst_seen <= 1'b1;
  end
  dpc_command_handler DUT (.*);
  dpc_host_model host (.*);
  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  //==================================================
  // helpers
  function automatic logic [31:0] step(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] fld(logic [15:0] v, int w);
    return v & 16'((32'h1 << w) - 1);
  endfunction
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic send(logic [15:0] c, logic [63:0] w);
    host.issue(c, w);
    if (host.tmo) begin
      err_count++;
      summarize();
    end
    @(posedge clk_sys);
  endtask
  // one-cycle pulse on vsync or on scan end, then let it settle
  task automatic pulse(logic sel);
    @(posedge clk_sys);
    if (sel) scan_picture_done <= 1'b1;
    else vsync <= 1'b1;
    @(posedge clk_sys);
    scan_picture_done <= 1'b0;
    vsync <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  //==================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    vsync = 1'b0;
    scan_picture_done = 1'b0;
    intra_seen = 1'b0;
    setup_needed = 1'b0;
    scan_irq_enable = 1'b1;
    err_count = 0;
    n_tests = 0;
    lfsr = 32'h839D;
    wb = 1'b1;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    cmp(16'(play_state), 16'(DPC_IDLE));
    cmp(16'(window_blank), 16'h0001);
    // blank and unblank with noise in the reserved bits
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      b = (i < 2) ? i[0] : lfsr[0];
      send(`DPC_CMD_BLANK, {48'h0, lfsr[15:1], b});
      cmp(16'(window_blank), 16'(wb));
      pulse(1'b0);
      wb = b;
      cmp(16'(window_blank), 16'(wb));
    end
    // border words from random values
    repeat (2) begin
      lfsr = step(lfsr);
      a = {lfsr, ~lfsr};
      send(`DPC_CMD_BORDER, a);
      pulse(1'b0);
      cmp(16'(left_offset), fld(a[15:0], 10));
      cmp(16'(top_offset), fld(a[31:16], 15));
      cmp(16'(red_colour), fld(a[47:32], 8));
      cmp({green_colour, blue_colour}, a[63:48]);
      cmp(16'(window_blank), 16'(wb));
    end
    send(`DPC_CMD_SCAN, 64'h0);
    cmp(16'(play_state), 16'(DPC_SCAN));
    cmp(16'(decode_run), 16'h0001);
    cmp(16'(sync_enable), 16'h0000);
    cmp(16'(discard_pred), 16'h0001);
    intra_seen <= 1'b1;
    pulse(1'b1);
    cmp(16'(play_state), 16'(DPC_PAUSE));
    cmp(16'(post_scan_picture), 16'h0001);
    cmp(16'(decode_run), 16'h0000);
    cmp(16'(irq_seen), 16'h0001);
    cmp(16'(discard_pred), 16'h0000);
    // play routed through setup
    setup_needed <= 1'b1;
    send(`DPC_CMD_PLAY, 64'h0);
    cmp(16'(play_state), 16'(DPC_PLAY));
    cmp(16'(sync_enable), 16'h0001);
    cmp(16'(decode_run), 16'h0001);
    send(`DPC_CMD_RESET, 64'h0);
    cmp(16'(play_state), 16'(DPC_IDLE));
    cmp(16'(window_blank), 16'h0001);
    cmp(16'(left_offset), 16'h0000);
    cmp(16'(top_offset), 16'h0000);
    cmp(16'(rst_seen), 16'h0001);
    cmp(16'(reset_busy), 16'h0000);
    summarize();
  end
endmodule
bind dpc_command_handler dpc_checker u_chk (.*);
`default_nettype wire
